// ==== rtl/dcp_channel.sv ====
// one channel of the dynamics processor with its AXI4-Lite register slave
// Function
// - attack sets how fast gain falls above threshold, 25 to 500 ms
// - release sets how fast gain recovers, 25 ms to 2 s
// - release is time per 10 dB, so recovery scales with reduction
// - release fully clockwise gives auto timing, auto light, fixed attack/release
// - hard knee: no reduction below threshold, full ratio above it
// - soft knee: gradual reduction through the knee, full ratio at top
// - knee 0 to 15 dB wide, threshold at knee centre
// - selector picks compressor or band gain operation per channel
// - listen sends side-chain signal to the output instead of program
// - listen indicator blinks while listen is engaged
// - compressor to listen keeps compressor light, blinks listen, hears filter
// - selecting band mode lights only the band indicator
// - band mode to listen keeps band light, blinks listen, hears band
// - compressor mode filter is a biquad shaping only the detector
// - filter gain centre setting is unity
// - compressor mode main path stays broadband
// - band mode filter sets side-chain band and matching main band
// - band mode compares band minus broadband level with threshold
// - limiter: instant attack, 25 ms hold, 6 dB/s release
// - limiter detector looks at an oversampled signal
// - headroom reads limiter threshold minus present peak
// - limit light on while level exceeds limiter threshold
// - limiter works in bypass; maximum threshold disables it
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "dcp_params.svh"
`default_nettype none
module dcp_channel #(
	parameter int CYC_PER_MS = `DCP_CYC_PER_MS,
	parameter int SAMPLE_W   = 24
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic signed [23:0]    in_sample,
	input  wire logic                  in_valid,
	output logic signed [23:0]         out_sample,
	output logic                       out_valid,
	output dcp_pkg::dcp_led_t          led
);
	// the sample path is fixed at 24 bits and the ballistics divide the ms count by 40
	if (SAMPLE_W != 24 || CYC_PER_MS < 40) begin : g_param_chk
		$error("dcp_channel: unsupported parameters");
	end
	localparam int LIM_HOLD_CYC = `DCP_LIM_HOLD_MS * CYC_PER_MS;
	localparam int LIM_REL_CYC  = 1000 * CYC_PER_MS / (`DCP_LIM_REL_DBPS * 4);
	localparam int BLINK_CYC    = `DCP_BLINK_MS * CYC_PER_MS;

	// log level in quarter dB: 6 dB per octave from the leading one plus 3 mantissa bits
	function automatic logic signed [11:0] lvl_db(input logic [22:0] m);
		logic [4:0] p;
		logic [2:0] f;
		p = 5'h00;
		for (int i = 0; i < 23; i++) if (m[i]) p = 5'(i);
		f = (p >= 5'h03) ? 3'(m >> (p - 5'h03)) : 3'(m << (5'h03 - p));
		if (m == 23'h000000) return `DCP_DB_FLOOR;
		return 12'((int'(p) * 8 + int'(f) - `DCP_DB_FS_CODE) * 3);
	endfunction : lvl_db

	function automatic logic [22:0] mag(input logic signed [23:0] x);
		logic [23:0] a;
		a = x[23] ? 24'(-x) : 24'(x);
		return a[23] ? 23'h7FFFFF : a[22:0];
	endfunction : mag

	// attenuate by g quarter dB: whole 6 dB steps by shift, remainder by a linear trim
	function automatic logic signed [23:0] atten(input logic signed [23:0] x, input logic [9:0] g);
		logic signed [23:0] y;
		logic signed [17:0] k;
		logic signed [41:0] p;
		y = x >>> (g / 10'h018);
		k = 18'(17'h08000 - 17'(g % 10'h018) * 17'h002AB);
		p = y * k;
		return 24'(p >>> 15);
	endfunction : atten

	// static gain curve; knee centred on threshold, quadratic across its span
	function automatic logic [9:0] curve(input logic signed [12:0] over, input logic [3:0] knee,
		input logic [3:0] ratio);
		logic [8:0] slope;
		logic signed [13:0] half;
		logic signed [31:0] t;
		slope = 9'h100 - 9'(9'h100 / ((ratio == 4'h0) ? 9'h001 : {5'h00, ratio}));
		half = 14'(knee) * 14'sh0002;
		t = 32'sh0;
		if (knee == 4'h0) begin
			if (over > 13'sh0) t = (32'(over) * 32'(slope)) >>> 8;
		end else if (14'(over) >= half) begin
			t = (32'(over) * 32'(slope)) >>> 8;
		end else if (14'(over) > -half) begin
			t = 32'(over + 13'(half));
			t = ((t * t * 32'(slope)) / (32'(half) * 4)) >>> 8;
		end
		return (t > 32'sh3FF) ? 10'h3FF : 10'(t);
	endfunction : curve

	// merge a write under byte strobes
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		for (int b = 0; b < 4; b++) if (s[b]) old[b*8 +: 8] = d[b*8 +: 8];
		return old;
	endfunction : wmerge

	dcp_pkg::dcp_cfg_t cfg_r, cfg_nxt;
	logic [7:0]  aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic [3:0]  w_strb_r, w_strb_nxt;
	logic        aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
	logic        awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
	logic [1:0]  bresp_nxt, rresp_nxt;
	logic [31:0] rdata_nxt;
	logic [9:0]  gr_r, gr_nxt, tgt_r, tgt_nxt, lim_gr_r, lim_gr_nxt;
	logic signed [12:0] headroom_r, headroom_nxt;
	logic [31:0] tick_r, tick_nxt, hold_r, hold_nxt, lrel_r, lrel_nxt, blink_cnt_r, blink_cnt_nxt;
	logic        blink_r, blink_nxt;
	dcp_pkg::dcp_ind_t ind_r, ind_nxt;
	dcp_pkg::dcp_led_t led_nxt;
	logic signed [23:0] x1_r, x2_r, y1_r, y2_r, main_prev_r, out_nxt;
	logic signed [23:0] sc, band, main_w, prog;
	logic signed [12:0] over, over_l;
	logic signed [11:0] peak_db;
	logic [9:0]  tgt_w, lim_eff;
	logic [15:0] atk_ms, rel_ms;
	logic [31:0] period;
	logic        auto_m, deq_m, lsn_m;

	// register file write/read over AXI4-Lite; status words ignore writes
	always_comb begin
		cfg_nxt = cfg_r;
		aw_addr_nxt = aw_addr_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		aw_full_nxt = aw_full_r;
		w_full_nxt = w_full_r;
		bvalid_nxt = s_axi_bvalid && !s_axi_bready;
		bresp_nxt = s_axi_bresp;
		arready_nxt = s_axi_arready;
		rvalid_nxt = s_axi_rvalid;
		rdata_nxt = s_axi_rdata;
		rresp_nxt = s_axi_rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_strb_nxt = s_axi_wstrb;
		end
		if (aw_full_r && w_full_r && !s_axi_bvalid) begin
			aw_full_nxt = 1'b0;
			w_full_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = 2'h0;
			if (aw_addr_r == `DCP_OFF_CTRL) begin
				{cfg_nxt.knee, cfg_nxt.bypass, cfg_nxt.sel} = 7'({w_data_r[7:4],
					w_data_r[2:0]});
				if (!w_strb_r[0]) {cfg_nxt.knee, cfg_nxt.bypass, cfg_nxt.sel} =
					{cfg_r.knee, cfg_r.bypass, cfg_r.sel};
			end else if (aw_addr_r == `DCP_OFF_THR) begin
				cfg_nxt.thr = 12'(wmerge(32'(cfg_r.thr), w_data_r, w_strb_r));
			end else if (aw_addr_r == `DCP_OFF_RATIO) begin
				cfg_nxt.ratio = 4'(wmerge(32'(cfg_r.ratio), w_data_r, w_strb_r));
			end else if (aw_addr_r == `DCP_OFF_ATK) begin
				cfg_nxt.atk_ms = 16'(wmerge(32'(cfg_r.atk_ms), w_data_r, w_strb_r));
			end else if (aw_addr_r == `DCP_OFF_REL) begin
				cfg_nxt.rel_ms = 16'(wmerge(32'(cfg_r.rel_ms), w_data_r, w_strb_r));
			end else if (aw_addr_r == `DCP_OFF_LIMTHR) begin
				cfg_nxt.lim_thr = 12'(wmerge(32'(cfg_r.lim_thr), w_data_r, w_strb_r));
			end else if (aw_addr_r == `DCP_OFF_B0) begin
				cfg_nxt.b0 = 16'(wmerge(32'(cfg_r.b0), w_data_r, w_strb_r));
			end else if (aw_addr_r == `DCP_OFF_B1) begin
				cfg_nxt.b1 = 16'(wmerge(32'(cfg_r.b1), w_data_r, w_strb_r));
			end else if (aw_addr_r == `DCP_OFF_B2) begin
				cfg_nxt.b2 = 16'(wmerge(32'(cfg_r.b2), w_data_r, w_strb_r));
			end else if (aw_addr_r == `DCP_OFF_A1) begin
				cfg_nxt.a1 = 16'(wmerge(32'(cfg_r.a1), w_data_r, w_strb_r));
			end else if (aw_addr_r == `DCP_OFF_A2) begin
				cfg_nxt.a2 = 16'(wmerge(32'(cfg_r.a2), w_data_r, w_strb_r));
			end else if (aw_addr_r == `DCP_OFF_STATUS || aw_addr_r == `DCP_OFF_HEADROOM ||
				aw_addr_r == `DCP_OFF_GAINRED) begin
				bresp_nxt = 2'h0;
			end else begin
				bresp_nxt = 2'h2;
			end
		end
		// an address slot stays closed until its write is carried out
		awready_nxt = !aw_full_nxt;
		wready_nxt = !w_full_nxt;
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_nxt = 1'b0;
			arready_nxt = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			arready_nxt = 1'b0;
			rvalid_nxt = 1'b1;
			rresp_nxt = 2'h0;
			rdata_nxt = 32'h0;
			if (s_axi_araddr == `DCP_OFF_CTRL) begin
				rdata_nxt = {24'h0, cfg_r.knee, 1'b0, cfg_r.bypass, cfg_r.sel};
			end else if (s_axi_araddr == `DCP_OFF_THR) begin
				rdata_nxt = 32'(cfg_r.thr);
			end else if (s_axi_araddr == `DCP_OFF_RATIO) begin
				rdata_nxt = {28'h0, cfg_r.ratio};
			end else if (s_axi_araddr == `DCP_OFF_ATK) begin
				rdata_nxt = {16'h0, cfg_r.atk_ms};
			end else if (s_axi_araddr == `DCP_OFF_REL) begin
				rdata_nxt = {16'h0, cfg_r.rel_ms};
			end else if (s_axi_araddr == `DCP_OFF_LIMTHR) begin
				rdata_nxt = 32'(cfg_r.lim_thr);
			end else if (s_axi_araddr == `DCP_OFF_B0) begin
				rdata_nxt = 32'(cfg_r.b0);
			end else if (s_axi_araddr == `DCP_OFF_B1) begin
				rdata_nxt = 32'(cfg_r.b1);
			end else if (s_axi_araddr == `DCP_OFF_B2) begin
				rdata_nxt = 32'(cfg_r.b2);
			end else if (s_axi_araddr == `DCP_OFF_A1) begin
				rdata_nxt = 32'(cfg_r.a1);
			end else if (s_axi_araddr == `DCP_OFF_A2) begin
				rdata_nxt = 32'(cfg_r.a2);
			end else if (s_axi_araddr == `DCP_OFF_STATUS) begin
				rdata_nxt = {25'h0, 2'(ind_r), led};
			end else if (s_axi_araddr == `DCP_OFF_HEADROOM) begin
				rdata_nxt = 32'(headroom_r);
			end else if (s_axi_araddr == `DCP_OFF_GAINRED) begin
				rdata_nxt = {6'h00, lim_gr_r, 6'h00, gr_r};
			end else begin
				rresp_nxt = 2'h2;
			end
		end
	end

	// indicator selector: listen remembers which side-chain it was entered from
	always_comb begin
		ind_nxt = ind_r;
		case (dcp_pkg::dcp_sel_t'(cfg_r.sel))
			dcp_pkg::DCP_SEL_COMP: ind_nxt = dcp_pkg::DCP_IND_COMP;
			dcp_pkg::DCP_SEL_DEQ: ind_nxt = dcp_pkg::DCP_IND_DEQ;
			dcp_pkg::DCP_SEL_LISTEN: begin
				if (ind_r == dcp_pkg::DCP_IND_COMP || ind_r == dcp_pkg::DCP_IND_COMP_LSN)
					ind_nxt = dcp_pkg::DCP_IND_COMP_LSN;
				else
					ind_nxt = dcp_pkg::DCP_IND_DEQ_LSN;
			end
			default: ind_nxt = ind_r;
		endcase
		blink_cnt_nxt = blink_cnt_r + 32'h1;
		blink_nxt = blink_r;
		if (blink_cnt_r >= 32'(BLINK_CYC - 1)) begin
			blink_cnt_nxt = 32'h0;
			blink_nxt = !blink_r;
		end
	end

	assign deq_m  = (ind_r == dcp_pkg::DCP_IND_DEQ || ind_r == dcp_pkg::DCP_IND_DEQ_LSN);
	assign lsn_m  = (ind_r == dcp_pkg::DCP_IND_COMP_LSN || ind_r == dcp_pkg::DCP_IND_DEQ_LSN);
	assign auto_m = (cfg_r.rel_ms > `DCP_REL_MAX_MS);
	// attack is clamped to the control's travel; release only at its bottom end, above it auto timing takes over
	assign atk_ms = auto_m ? `DCP_AUTO_ATK_MS : (cfg_r.atk_ms < `DCP_ATK_MIN_MS) ? `DCP_ATK_MIN_MS :
		(cfg_r.atk_ms > `DCP_ATK_MAX_MS) ? `DCP_ATK_MAX_MS : cfg_r.atk_ms;
	assign rel_ms = auto_m ? `DCP_AUTO_REL_MS : (cfg_r.rel_ms < `DCP_REL_MIN_MS) ? `DCP_REL_MIN_MS :
		cfg_r.rel_ms;

	// side-chain biquad; unity b0 with zero taps is the 0 dB centre
	always_comb begin
		logic signed [43:0] acc;
		acc = 44'(in_sample * cfg_r.b0) + 44'(x1_r * cfg_r.b1) + 44'(x2_r * cfg_r.b2) -
			44'(y1_r * cfg_r.a1) - 44'(y2_r * cfg_r.a2);
		sc = 24'(acc >>> `DCP_COEF_FRAC);
		band = sc - in_sample;
		// compressor detector hears the filter; band mode weighs band against broadband
		if (deq_m)
			over = 13'(lvl_db(mag(band))) - 13'(lvl_db(mag(in_sample))) - 13'(cfg_r.thr);
		else
			over = 13'(lvl_db(mag(sc))) - 13'(cfg_r.thr);
		tgt_w = curve(over, cfg_r.knee, cfg_r.ratio);
		if (cfg_r.bypass)
			prog = in_sample;
		else if (deq_m)
			prog = in_sample - band + atten(band, gr_r);
		else
			prog = atten(in_sample, gr_r);
		main_w = lsn_m ? (deq_m ? band : sc) : prog;
		// interpolated midpoint doubles the detector rate to catch inter-sample peaks
		peak_db = lvl_db(mag(24'((25'(main_w) + 25'(main_prev_r)) >>> 1)));
		if (lvl_db(mag(main_w)) > peak_db) peak_db = lvl_db(mag(main_w));
		over_l = 13'(peak_db) - 13'(cfg_r.lim_thr);
		// gain words are unsigned: compare them as positive signed values, clamp the top
		if (over_l <= $signed({3'h0, lim_gr_r}))
			lim_eff = lim_gr_r;
		else if (over_l > 13'sh03FF)
			lim_eff = 10'h3FF;
		else
			lim_eff = 10'(over_l);
		out_nxt = in_valid ? atten(main_w, lim_eff) : out_sample;
	end

	// compressor ballistics: one quarter dB step per tick, tick period from the time setting
	always_comb begin
		period = 32'((gr_r < tgt_r) ? atk_ms : rel_ms) * 32'(CYC_PER_MS / `DCP_QDB_PER_10DB);
		tick_nxt = tick_r + 32'h1;
		gr_nxt = gr_r;
		tgt_nxt = in_valid ? tgt_w : tgt_r;
		if (gr_r == tgt_r) begin
			tick_nxt = 32'h0;
		end else if (tick_r >= period - 32'h1) begin
			tick_nxt = 32'h0;
			if (gr_r < tgt_r) gr_nxt = gr_r + 10'h001;
			else gr_nxt = gr_r - 10'h001;
		end
		// limiter: take a new peak at once, hold it, then fall at the fixed rate
		lim_gr_nxt = lim_gr_r;
		hold_nxt = (hold_r != 32'h0) ? hold_r - 32'h1 : 32'h0;
		lrel_nxt = 32'h0;
		if (in_valid && over_l > $signed({3'h0, lim_gr_r})) begin
			lim_gr_nxt = lim_eff;
			hold_nxt = 32'(LIM_HOLD_CYC);
		end else if (hold_r == 32'h0 && lim_gr_r != 10'h000) begin
			lrel_nxt = lrel_r + 32'h1;
			if (lrel_r >= 32'(LIM_REL_CYC - 1)) begin
				lrel_nxt = 32'h0;
				lim_gr_nxt = lim_gr_r - 10'h001;
			end
		end
		headroom_nxt = in_valid ? 13'(cfg_r.lim_thr) - 13'(peak_db) : headroom_r;
		led_nxt.comp = !deq_m;
		led_nxt.deq = deq_m;
		led_nxt.listen = lsn_m && blink_r;
		led_nxt.auto_t = auto_m;
		led_nxt.limit = in_valid ? (over_l > 13'sh0) : led.limit;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r <= '{sel: 2'h0, bypass: 1'b0, knee: 4'h0, thr: `DCP_RST_THR,
				ratio: `DCP_RST_RATIO, atk_ms: `DCP_RST_ATK, rel_ms: `DCP_RST_REL,
				lim_thr: `DCP_RST_LIMTHR, b0: `DCP_RST_UNITY, b1: 16'h0000, b2: 16'h0000,
				a1: 16'h0000, a2: 16'h0000};
			{aw_addr_r, w_data_r, w_strb_r, aw_full_r, w_full_r} <= '0;
			{s_axi_awready, s_axi_wready, s_axi_arready} <= 3'h7;
			{s_axi_bvalid, s_axi_bresp, s_axi_rvalid, s_axi_rresp, s_axi_rdata} <= '0;
			ind_r <= dcp_pkg::DCP_IND_COMP;
			{blink_cnt_r, blink_r, tick_r, gr_r, tgt_r, hold_r, lrel_r, lim_gr_r} <= '0;
			{x1_r, x2_r, y1_r, y2_r, main_prev_r, out_sample, out_valid, headroom_r} <= '0;
			led <= '0;
		end else begin
			cfg_r <= cfg_nxt;
			{aw_addr_r, w_data_r, w_strb_r} <= {aw_addr_nxt, w_data_nxt, w_strb_nxt};
			{aw_full_r, w_full_r} <= {aw_full_nxt, w_full_nxt};
			{s_axi_awready, s_axi_wready, s_axi_arready} <= {awready_nxt, wready_nxt, arready_nxt};
			{s_axi_bvalid, s_axi_bresp} <= {bvalid_nxt, bresp_nxt};
			{s_axi_rvalid, s_axi_rresp, s_axi_rdata} <= {rvalid_nxt, rresp_nxt, rdata_nxt};
			ind_r <= ind_nxt;
			{blink_cnt_r, blink_r} <= {blink_cnt_nxt, blink_nxt};
			{tick_r, gr_r, tgt_r} <= {tick_nxt, gr_nxt, tgt_nxt};
			{hold_r, lrel_r, lim_gr_r, headroom_r} <= {hold_nxt, lrel_nxt, lim_gr_nxt, headroom_nxt};
			if (in_valid) begin
				{x2_r, x1_r, y2_r, y1_r, main_prev_r} <= {x1_r, in_sample, y1_r, sc, main_w};
			end
			out_sample <= out_nxt;
			out_valid <= in_valid;
			led <= led_nxt;
		end
	end

	default clocking dcp_cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sample_out_a: assert property (in_valid |=> out_valid ##1 !out_valid || $past(in_valid))
		else $error("output strobe does not follow input strobe");
	listen_blink_a: assert property (!lsn_m |=> !led.listen)
		else $error("listen light on outside listen");
	deq_lights_a: assert property (cfg_r.sel == 2'h1 ##1 cfg_r.sel == 2'h1 |=>
		led.deq && !led.comp && !led.listen)
		else $error("band mode lights wrong");
	comp_listen_a: assert property (ind_r == dcp_pkg::DCP_IND_COMP && cfg_r.sel == 2'h2 |=>
		##1 led.comp && !led.deq)
		else $error("compressor light lost on entering listen");
	limit_light_a: assert property (in_valid && over_l > 13'sh0 |=> led.limit)
		else $error("limit light missing over threshold");
	lim_hold_a: assert property (hold_r != 32'h0 |=> lim_gr_r >= $past(lim_gr_r))
		else $error("limiter released during hold");
	rel_ramp_a: assert property (gr_r < $past(gr_r) |-> $past(gr_r) - gr_r == 10'h001)
		else $error("release not a single-step ramp");
	lim_off_a: assert property (in_valid && cfg_r.lim_thr == 12'h000 |=> !led.limit)
		else $error("limiter acts at maximum threshold");
	auto_light_a: assert property (cfg_r.rel_ms > `DCP_REL_MAX_MS |=> led.auto_t)
		else $error("auto light missing");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
endmodule : dcp_channel
`default_nettype wire

// ==== rtl/dcp_params.svh ====
// offsets, reset values and timing constants of the dynamics channel processor
`ifndef DCP_PARAMS_SVH
`define DCP_PARAMS_SVH
`define DCP_OFF_CTRL      8'h00
`define DCP_OFF_THR       8'h04
`define DCP_OFF_RATIO     8'h08
`define DCP_OFF_ATK       8'h0C
`define DCP_OFF_REL       8'h10
`define DCP_OFF_LIMTHR    8'h14
`define DCP_OFF_B0        8'h18
`define DCP_OFF_B1        8'h1C
`define DCP_OFF_B2        8'h20
`define DCP_OFF_A1        8'h24
`define DCP_OFF_A2        8'h28
`define DCP_OFF_STATUS    8'h2C
`define DCP_OFF_HEADROOM  8'h30
`define DCP_OFF_GAINRED   8'h34
// control register fields
`define DCP_CTRL_SEL_LSB  0
`define DCP_CTRL_BYP_BIT  2
`define DCP_CTRL_KNEE_LSB 4
// reset values; levels are in quarter dB, 0 is full scale
`define DCP_RST_CTRL      32'h0000_0000
`define DCP_RST_THR       12'hFB0
`define DCP_RST_RATIO     4'h1
`define DCP_RST_ATK       16'h0019
`define DCP_RST_REL       16'h01F4
`define DCP_RST_LIMTHR    12'h000
`define DCP_RST_UNITY     16'h4000
// timing, in the units named
`define DCP_CLK_MHZ       200
`define DCP_CYC_PER_MS    (`DCP_CLK_MHZ * 1000)
`define DCP_QDB_PER_10DB  40
`define DCP_ATK_MIN_MS    16'h0019
`define DCP_ATK_MAX_MS    16'h01F4
`define DCP_REL_MIN_MS    16'h0019
`define DCP_REL_MAX_MS    16'h07D0
`define DCP_AUTO_ATK_MS   16'h0032
`define DCP_AUTO_REL_MS   16'h01F4
`define DCP_LIM_HOLD_MS   25
`define DCP_LIM_REL_DBPS  6
`define DCP_BLINK_MS      250
`define DCP_DB_FLOOR      12'hDA8
`define DCP_DB_FS_CODE    183
`define DCP_COEF_FRAC     14
`endif

// ==== rtl/dcp_pkg.sv ====
// types of the dynamics channel processor
`default_nettype none
package dcp_pkg;
	typedef enum logic [1:0] {DCP_SEL_COMP, DCP_SEL_DEQ, DCP_SEL_LISTEN, DCP_SEL_NONE} dcp_sel_t;
	typedef enum logic [1:0] {DCP_IND_COMP, DCP_IND_DEQ, DCP_IND_COMP_LSN, DCP_IND_DEQ_LSN} dcp_ind_t;
	typedef struct packed {
		logic               comp;
		logic               deq;
		logic               listen;
		logic               auto_t;
		logic               limit;
	} dcp_led_t;
	typedef struct packed {
		logic [1:0]         sel;
		logic               bypass;
		logic [3:0]         knee;
		logic signed [11:0] thr;
		logic [3:0]         ratio;
		logic [15:0]        atk_ms;
		logic [15:0]        rel_ms;
		logic signed [11:0] lim_thr;
		logic signed [15:0] b0;
		logic signed [15:0] b1;
		logic signed [15:0] b2;
		logic signed [15:0] a1;
		logic signed [15:0] a2;
	} dcp_cfg_t;
endpackage : dcp_pkg
`default_nettype wire

// ==== test/dcp_audio_src.sv ====
// audio source and sink model on the channel's sample ports
`timescale 1ns/1ps
`default_nettype none
module dcp_audio_src (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic signed [23:0] smp,
	input  wire logic signed [23:0] out_sample,
	input  wire logic               out_valid,
	output logic signed [23:0]      in_sample,
	output logic                    in_valid,
	output logic signed [23:0]      last_out
);
	logic [2:0] cnt_r;
	// one sample per eight clocks; off the strobe the data flips to its inverse and back on every clock
	always_ff @(posedge aclk) begin
		cnt_r <= aresetn ? cnt_r + 3'h1 : 3'h0;
		in_valid <= aresetn && cnt_r == 3'h7;
		in_sample <= !aresetn ? 24'h000000 : (cnt_r == 3'h7) ? smp : ~in_sample;
		if (out_valid) begin
			last_out <= out_sample;
		end
	end
endmodule : dcp_audio_src
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench of the dynamics channel processor
`timescale 1ns/1ps
`include "dcp_params.svh"
`default_nettype none
module tb;
	logic               aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic               arvalid, arready, rvalid, rready, in_valid, out_valid, old_l;
	logic [7:0]         awaddr, araddr;
	logic [31:0]        wdata, rdata, rd_d;
	logic [3:0]         wstrb;
	logic [1:0]         bresp, rresp, resp;
	logic signed [23:0] smp, in_sample, out_sample, last_out;
	dcp_pkg::dcp_led_t  led;
	int                 miscompares, num_checks, n;
	logic [7:0]         adr [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
	logic [31:0]        rst [8] = '{32'h0, 32'hFFFFFFB0, 32'h1, 32'h19, 32'h1F4, 32'h0, 32'h4000, 32'h0};
	dcp_channel #(.CYC_PER_MS(40)) u_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.in_sample(in_sample), .in_valid(in_valid), .out_sample(out_sample),
		.out_valid(out_valid), .led(led));
	dcp_audio_src u_src (.aclk(aclk), .aresetn(aresetn), .smp(smp), .out_sample(out_sample),
		.out_valid(out_valid), .in_sample(in_sample), .in_valid(in_valid), .last_out(last_out));
	// 5 ns clock
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// a wait that used up its bound ends the run as a mismatch
	task automatic bound(input int lim);
		if (n >= lim) begin
			chk(32'h0, 32'h1);
			give_verdict();
		end
	endtask : bound
	// each channel is released at its own handshake; bready stays up until bvalid is seen
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		n = 0;
		@(posedge aclk);
		{awaddr, wdata, wstrb} <= {a, d, s};
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		resp = bresp;
		bready <= 1'b0;
		bound(50);
		repeat (2) @(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		n = 0;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		{rd_d, resp} = {rdata, rresp};
		rready <= 1'b0;
		bound(50);
	endtask : rd
	// waits for the listen light to change phase
	task automatic tog_wait;
		n = 0;
		old_l = led.listen;
		do begin
			@(posedge aclk);
			n++;
		end while (led.listen === old_l && n < 10100);
		bound(10100);
	endtask : tog_wait
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, wstrb, smp} = 76'h0;
		{miscompares, num_checks} = 64'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		chk({27'h0, led}, 32'h10);
		for (int i = 0; i < 8; i++) begin
			rd(adr[i]);
			chk(rd_d, rst[i]);
		end
		rd(8'h40);
		chk({30'h0, resp}, 32'h2);
		chk(rd_d, 32'h0);
		wr(8'h40, 32'h1, 4'hF);
		chk({30'h0, resp}, 32'h2);
		wr(`DCP_OFF_HEADROOM, 32'h5, 4'hF);
		chk({30'h0, resp}, 32'h0);
		// below threshold even a 10:1 ratio leaves the broadband path untouched
		wr(`DCP_OFF_RATIO, 32'hA, 4'hF);
		smp <= 24'h012345;
		repeat (40) @(posedge aclk);
		chk({8'h00, last_out}, 32'h012345);
		// half gain detector filter, heard in listen from compressor mode
		wr(`DCP_OFF_B0, 32'h2000, 4'hF);
		wr(`DCP_OFF_CTRL, 32'h2, 4'hF);
		smp <= 24'h100000;
		repeat (40) @(posedge aclk);
		chk({31'h0, led.comp}, 32'h1);
		chk({8'h00, last_out}, 32'h080000);
		tog_wait();
		tog_wait();
		chk({31'h0, n > 9990 && n < 10010}, 32'h1);
		wr(`DCP_OFF_CTRL, 32'h1, 4'hE);
		chk({31'h0, led.deq}, 32'h0);
		wr(`DCP_OFF_CTRL, 32'h1, 4'hF);
		chk({27'h0, led} & 32'h1C, 32'h08);
		wr(`DCP_OFF_CTRL, 32'h2, 4'hF);
		repeat (40) @(posedge aclk);
		chk({27'h0, led} & 32'h18, 32'h08);
		chk({8'h00, last_out}, 32'hF80000);
		wr(`DCP_OFF_REL, 32'h7D1, 4'hF);
		chk({31'h0, led.auto_t}, 32'h1);
		wr(`DCP_OFF_REL, 32'h1F4, 4'hF);
		chk({31'h0, led.auto_t}, 32'h0);
		// limiter keeps working with the channel bypassed
		wr(`DCP_OFF_CTRL, 32'h4, 4'hF);
		wr(`DCP_OFF_LIMTHR, 32'hFFFFFFE8, 4'hF);
		smp <= 24'h7FFFF0;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (led.limit !== 1'b1 && n < 200);
		chk({31'h0, led.limit}, 32'h1);
		rd(`DCP_OFF_HEADROOM);
		// full-scale peak against a threshold 6 dB down: -6 dB headroom, output halved at once
		chk(rd_d, 32'hFFFFFFE8);
		chk({8'h00, last_out}, 32'h3FFFF8);
		give_verdict();
	end
endmodule : tb
`default_nettype wire
